// ===== logic/home_seq_defs.vh
`ifndef HOME_SEQ_DEFS_VH
`define HOME_SEQ_DEFS_VH

// Register offsets (byte addresses, 32-bit words)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STAT    8'h08
`define REG_IRQ_MASK    8'h0C
`define REG_LOG_SEL     8'h10
`define REG_LOG_DATA    8'h14
`define REG_CLEARANCE   8'h18
`define REG_SLOT_QUERY  8'h1C
`define REG_FAIL_UNITS  8'h20

// Control bits
`define CTRL_START      0
`define CTRL_SINGLE     1
`define CTRL_SPEED_LO   2
`define CTRL_SPEED_HI   3
`define CTRL_LOG_CLEAR  4

// Speed selects
`define SPEED_FULL      2'h0
`define SPEED_HALF      2'h1
`define SPEED_QUARTER   2'h2

// Error codes, hexadecimal
`define ERR_NONE        8'h00
`define ERR_PICKER      8'h40
`define ERR_FLIP_AREA   8'h44
`define ERR_FINGERS     8'h45
`define ERR_HOME_POS    8'h46
`define ERR_HARDWARE    8'hF0

// Macro-move identifier of the homing routine
`define MACRO_HOME      8'h01

// First micro-move of each step
`define MICRO_MOVE_IDENTIFIER_STEP1      8'h56
`define MICRO_MOVE_IDENTIFIER_STEP2      8'h49
`define MICRO_MOVE_IDENTIFIER_STEP3      8'h4D
`define MICRO_MOVE_IDENTIFIER_STEP4      8'h47

`define FAIL_LIMIT      3'h4
`define SLOTS_PER_GROUP 16'h0004

// Extended log field selects
`define LOG_ENTRY       3'h0
`define LOG_MOVES       3'h1
`define LOG_MACRO       3'h2
`define LOG_MM1_ID      3'h3
`define LOG_MM1_ERR     3'h4
`define LOG_MM2_ID      3'h5
`define LOG_MM2_ERR     3'h6
`define LOG_TILT        3'h7

// Interrupt status bits
`define IRQ_DONE        0
`define IRQ_FAIL        1
`define IRQ_HW_ERR      2

`endif

// ===== logic/autochanger_home_sequencer.v
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`include "home_seq_defs.vh"

// Summary of operation
// - Step one frees picker fingers; failure logs error 40.
// - Step two clears flip area; carriage failure logs error 44.
// - Step three retracts fingers, calibrates flip; failure logs error 45.
// - Step four drives carriage to drive-end hard stop; failure logs 46.
// - Steps repeat in order until all pass or four failures accumulate.
// - At the limit, flag three replaceable units and report one hardware error.
// - Single-execution mode runs each motion once with no recovery.
// - Motions may run at half or quarter speed by selection.
// - Homing errors are micro-move codes, hidden from the panel.
// - All error numbers are encoded in hexadecimal.
// - Extended log fields follow the fixed documented order.
// - Move count counts moves since logs were last zeroed.
// - Stack tilt log always reads zero.
// - Clearance log reports up and down values, two's complement.
// - Slots group by four from the drive end, numbering upward.
module autochanger_home_sequencer (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_ff,
  // Motion mechanism
  output reg         move_req_ff,
  output reg  [7:0]  micro_move_identifier_ff,
  output reg  [1:0]  move_speed_ff,
  input  wire        move_done,
  input  wire        move_fail,
  // Clearance test results
  input  wire [15:0] clear_up,
  input  wire [15:0] clear_down,
  // Panel-visible status
  output reg  [7:0]  panel_error_ff,
  output reg         irq_ff
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ISSUE = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_PASS = 3'h3;
  localparam ST_HWERR = 3'h4;

  reg [2:0]  state_ff;
  reg [2:0]  nxt_state;
  reg [1:0]  step_ff;
  reg [1:0]  nxt_step;
  reg [2:0]  fail_cnt_ff;
  reg [2:0]  nxt_fail_cnt;
  reg        single_ff;
  reg [1:0]  speed_ff;
  reg [2:0]  log_sel_ff;
  reg [2:0]  irq_stat_ff;
  reg [2:0]  irq_mask_ff;
  reg [2:0]  fru_ff;
  reg [7:0]  last_err_ff;
  reg [15:0] log_entry_ff;
  reg [31:0] moves_since_clear_ff;
  reg [7:0]  macro_move_id_ff;
  reg [7:0]  first_micro_move_id_ff;
  reg [7:0]  first_micro_move_error_ff;
  reg [7:0]  second_micro_move_id_ff;
  reg [7:0]  second_micro_move_error_ff;
  reg        second_valid_ff;

  reg [7:0]  step_micro_move_identifier;
  reg [7:0]  step_err;
  reg [31:0] log_word;
  reg [31:0] nxt_rdata;
  reg [2:0]  ev;

  wire start_wr  = reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_START];
  wire log_clear = reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_LOG_CLEAR];
  wire step_fail = (state_ff == ST_WAIT) && move_fail;
  wire step_ok   = (state_ff == ST_WAIT) && move_done && !move_fail;

  // Step to micro-move and error code mapping
  always @* begin
    case (step_ff)
      2'h0: begin
        step_micro_move_identifier = `MICRO_MOVE_IDENTIFIER_STEP1;
        step_err  = `ERR_PICKER;
      end
      2'h1: begin
        step_micro_move_identifier = `MICRO_MOVE_IDENTIFIER_STEP2;
        step_err  = `ERR_FLIP_AREA;
      end
      2'h2: begin
        step_micro_move_identifier = `MICRO_MOVE_IDENTIFIER_STEP3;
        step_err  = `ERR_FINGERS;
      end
      default: begin
        step_micro_move_identifier = `MICRO_MOVE_IDENTIFIER_STEP4;
        step_err  = `ERR_HOME_POS;
      end
    endcase
  end

  // Sequencer
  always @* begin
    nxt_state    = state_ff;
    nxt_step     = step_ff;
    nxt_fail_cnt = fail_cnt_ff;
    ev           = 3'h0;
    case (state_ff)
      ST_IDLE: begin
        if (start_wr) begin
          nxt_state    = ST_ISSUE;
          nxt_step     = 2'h0;
          nxt_fail_cnt = 3'h0;
        end
      end
      ST_ISSUE: begin
        nxt_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (step_fail) begin
          nxt_fail_cnt = fail_cnt_ff + 3'h1;
          ev[`IRQ_FAIL] = 1'b1;
          if (single_ff) begin
            // No recovery: stop on first failure
            nxt_state = ST_IDLE;
          end else if (fail_cnt_ff + 3'h1 >= `FAIL_LIMIT) begin
            nxt_state = ST_HWERR;
            ev[`IRQ_HW_ERR] = 1'b1;
          end else begin
            nxt_state = ST_ISSUE;
            nxt_step  = 2'h0;
          end
        end else if (step_ok) begin
          if (step_ff == 2'h3) begin
            nxt_state = ST_PASS;
          end else begin
            nxt_step  = step_ff + 2'h1;
            nxt_state = ST_ISSUE;
          end
        end
      end
      ST_PASS: begin
        nxt_fail_cnt = 3'h0;
        ev[`IRQ_DONE] = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: begin
        if (start_wr) begin
          nxt_state    = ST_ISSUE;
          nxt_step     = 2'h0;
          nxt_fail_cnt = 3'h0;
        end
      end
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff    <= ST_IDLE;
      step_ff     <= 2'h0;
      fail_cnt_ff <= 3'h0;
      move_req_ff <= 1'b0;
      micro_move_identifier_ff <= 8'h00;
      move_speed_ff <= `SPEED_FULL;
    end else begin
      state_ff    <= nxt_state;
      step_ff     <= nxt_step;
      fail_cnt_ff <= nxt_fail_cnt;
      move_req_ff <= (nxt_state == ST_ISSUE);
      if (nxt_state == ST_ISSUE) begin
        micro_move_identifier_ff <= (nxt_step == 2'h0) ? `MICRO_MOVE_IDENTIFIER_STEP1 :
                                    (nxt_step == 2'h1) ? `MICRO_MOVE_IDENTIFIER_STEP2 :
                                    (nxt_step == 2'h2) ? `MICRO_MOVE_IDENTIFIER_STEP3 : `MICRO_MOVE_IDENTIFIER_STEP4;
      end
      move_speed_ff <= speed_ff;
    end
  end

  // Failure attribution and error reporting
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fru_ff         <= 3'h0;
      last_err_ff    <= `ERR_NONE;
      panel_error_ff <= `ERR_NONE;
    end else begin
      if (step_fail) begin
        last_err_ff <= step_err;
      end
      if (ev[`IRQ_HW_ERR]) begin
        // One bit per replaceable unit: picker, carriage, flip
        fru_ff <= {step_err == `ERR_FINGERS, step_err == `ERR_FLIP_AREA || step_err == `ERR_HOME_POS,
                   step_err == `ERR_PICKER} | fru_ff | 3'h7;
        panel_error_ff <= `ERR_HARDWARE;
      end else if (start_wr) begin
        fru_ff         <= 3'h0;
        panel_error_ff <= `ERR_NONE;
      end
    end
  end

  // Extended log
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      log_entry_ff               <= 16'h0000;
      moves_since_clear_ff       <= 32'h00000000;
      macro_move_id_ff           <= 8'h00;
      first_micro_move_id_ff     <= 8'h00;
      first_micro_move_error_ff  <= 8'h00;
      second_micro_move_id_ff    <= 8'h00;
      second_micro_move_error_ff <= 8'h00;
      second_valid_ff            <= 1'b0;
    end else if (log_clear) begin
      log_entry_ff               <= 16'h0000;
      moves_since_clear_ff       <= 32'h00000000;
      second_valid_ff            <= 1'b0;
    end else begin
      if (move_req_ff) begin
        moves_since_clear_ff <= moves_since_clear_ff + 32'h1;
      end
      if (step_fail) begin
        macro_move_id_ff <= `MACRO_HOME;
        if (fail_cnt_ff == 3'h0 || !second_valid_ff && log_entry_ff == 16'h0000) begin
          log_entry_ff              <= log_entry_ff + 16'h1;
          first_micro_move_id_ff    <= micro_move_identifier_ff;
          first_micro_move_error_ff <= step_err;
          second_valid_ff           <= 1'b0;
        end else begin
          second_micro_move_id_ff    <= micro_move_identifier_ff;
          second_micro_move_error_ff <= step_err;
          second_valid_ff            <= 1'b1;
        end
      end
    end
  end

  // Log field select, fixed order
  always @* begin
    case (log_sel_ff)
      `LOG_ENTRY:   log_word = {16'h0000, log_entry_ff};
      `LOG_MOVES:   log_word = moves_since_clear_ff;
      `LOG_MACRO:   log_word = {24'h000000, macro_move_id_ff};
      `LOG_MM1_ID:  log_word = {24'h000000, first_micro_move_id_ff};
      `LOG_MM1_ERR: log_word = {24'h000000, first_micro_move_error_ff};
      `LOG_MM2_ID:  log_word = second_valid_ff ? {24'h000000, second_micro_move_id_ff} : 32'h00000000;
      `LOG_MM2_ERR: log_word = second_valid_ff ? {24'h000000, second_micro_move_error_ff} : 32'h00000000;
      default:      log_word = 32'h00000000;
    endcase
  end

  // Register write side
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      single_ff   <= 1'b0;
      speed_ff    <= `SPEED_FULL;
      log_sel_ff  <= `LOG_ENTRY;
      irq_mask_ff <= 3'h0;
    end else if (reg_wr) begin
      if (reg_addr == `REG_CTRL) begin
        single_ff <= reg_wdata[`CTRL_SINGLE];
        speed_ff  <= reg_wdata[`CTRL_SPEED_HI:`CTRL_SPEED_LO];
      end else if (reg_addr == `REG_IRQ_MASK) begin
        irq_mask_ff <= reg_wdata[2:0];
      end else if (reg_addr == `REG_LOG_SEL) begin
        log_sel_ff <= reg_wdata[2:0];
      end
    end
  end

  // Read side; status cleared on read, new events win
  always @* begin
    if (reg_addr == `REG_CTRL)
      nxt_rdata = {28'h0000000, speed_ff, single_ff, 1'b0};
    else if (reg_addr == `REG_STATUS)
      nxt_rdata = {16'h0000, last_err_ff, 1'b0, fail_cnt_ff, 1'b0, state_ff};
    else if (reg_addr == `REG_IRQ_STAT)
      nxt_rdata = {29'h00000000, irq_stat_ff};
    else if (reg_addr == `REG_IRQ_MASK)
      nxt_rdata = {29'h00000000, irq_mask_ff};
    else if (reg_addr == `REG_LOG_SEL)
      nxt_rdata = {29'h00000000, log_sel_ff};
    else if (reg_addr == `REG_LOG_DATA)
      nxt_rdata = log_word;
    else if (reg_addr == `REG_CLEARANCE)
      nxt_rdata = {clear_up, clear_down};
    else if (reg_addr == `REG_SLOT_QUERY)
      nxt_rdata = {16'h0000, reg_wdata[15:0] / `SLOTS_PER_GROUP + 16'h1};
    else if (reg_addr == `REG_FAIL_UNITS)
      nxt_rdata = {29'h00000000, fru_ff};
    else
      nxt_rdata = 32'h00000000;
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_ff <= 32'h00000000;
      irq_stat_ff  <= 3'h0;
      irq_ff       <= 1'b0;
    end else begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : 32'h00000000;
      if (reg_rd && reg_addr == `REG_IRQ_STAT)
        irq_stat_ff <= ev;
      else
        irq_stat_ff <= irq_stat_ff | ev;
      irq_ff <= |(((reg_rd && reg_addr == `REG_IRQ_STAT) ? ev : (irq_stat_ff | ev)) & irq_mask_ff);
    end
  end

endmodule

// ===== sim/motion_model.sv
`timescale 1ns/10ps
module motion_model (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       arst_n,
  // Request from the sequencer
  input  wire       move_req,
  input  wire [7:0] move_id,
  // Bench control
  input  wire [7:0] bad_id,
  input  wire [2:0] fail_n,
  input  wire [3:0] lag,
  // Outcome pulses
  output reg        done_ff,
  output reg        fail_ff
);
  reg [3:0] wait_ff;
  reg [2:0] used_ff;
  reg       busy_ff;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_ff <= 4'h0;
      used_ff <= 3'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      if (move_req) begin
        busy_ff <= 1'b1;
        wait_ff <= lag;
      end else if (busy_ff && wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end else if (busy_ff) begin
        busy_ff <= 1'b0;
        // Chosen step stalls, so the sequencer sees a real fault
        if (move_id == bad_id && used_ff < fail_n) begin
          fail_ff <= 1'b1;
          used_ff <= used_ff + 3'h1;
        end else begin
          done_ff <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== sim/home_seq_props.sv
`timescale 1ns/10ps
`include "home_seq_defs.vh"
module home_seq_props (
  // Clock and reset
  input wire        ref_clk,
  input wire        arst_n,
  // Register port
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata_ff,
  // Motion and clearance
  input wire        move_req_ff,
  input wire [7:0]  micro_move_identifier_ff,
  input wire [1:0]  move_speed_ff,
  input wire        move_done,
  input wire        move_fail,
  input wire [15:0] clear_up,
  input wire [15:0] clear_down,
  // Status
  input wire [7:0]  panel_error_ff,
  input wire        irq_ff
);
  reg  [7:0] pid_ff;
  reg        pok_ff;
  reg  [2:0] sel_ff;
  wire [7:0] id = micro_move_identifier_ff;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pid_ff <= 8'h00;
      pok_ff <= 1'b0;
      sel_ff <= 3'h0;
    end else begin
      if (move_req_ff)
        pid_ff <= id;
      if (move_done || move_fail)
        pok_ff <= !move_fail;
      if (reg_wr && reg_addr == `REG_LOG_SEL)
        sel_ff <= reg_wdata[2:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  chk_step_two: assert property (move_req_ff && id == `MICRO_MOVE_IDENTIFIER_STEP2 |-> pid_ff == `MICRO_MOVE_IDENTIFIER_STEP1 && pok_ff)
    else $error("step two out of order");
  chk_step_three: assert property (move_req_ff && id == `MICRO_MOVE_IDENTIFIER_STEP3 |-> pid_ff == `MICRO_MOVE_IDENTIFIER_STEP2 && pok_ff)
    else $error("step three out of order");
  chk_step_four: assert property (move_req_ff && id == `MICRO_MOVE_IDENTIFIER_STEP4 |-> pid_ff == `MICRO_MOVE_IDENTIFIER_STEP3 && pok_ff)
    else $error("step four out of order");
  chk_restart_one: assert property (move_req_ff && (!pok_ff || pid_ff == `MICRO_MOVE_IDENTIFIER_STEP4) |-> id == `MICRO_MOVE_IDENTIFIER_STEP1)
    else $error("pass not begun at step one");
  chk_panel_code: assert property (panel_error_ff == `ERR_NONE || panel_error_ff == `ERR_HARDWARE)
    else $error("step code on panel");
  chk_tilt_zero: assert property (reg_rd && reg_addr == `REG_LOG_DATA && sel_ff == `LOG_TILT |=> reg_rdata_ff == 0)
    else $error("tilt log not zero");
  chk_clear_pair: assert property (reg_rd && reg_addr == `REG_CLEARANCE |=>
    reg_rdata_ff == {$past(clear_up), $past(clear_down)})
    else $error("clearance pair wrong");
  chk_slot_group: assert property (reg_rd && reg_addr == `REG_SLOT_QUERY |=>
    reg_rdata_ff == ({16'h0, $past(reg_wdata[15:0])} >> 2) + 32'h1)
    else $error("slot group wrong");
  cover property (move_fail);
  cover property (move_req_ff && id == `MICRO_MOVE_IDENTIFIER_STEP4);
  cover property (panel_error_ff == `ERR_HARDWARE);
endmodule
bind autochanger_home_sequencer home_seq_props u_props (.ref_clk(ref_clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
  .move_req_ff(move_req_ff), .micro_move_identifier_ff(micro_move_identifier_ff),
  .move_speed_ff(move_speed_ff), .move_done(move_done), .move_fail(move_fail), .clear_up(clear_up),
  .clear_down(clear_down), .panel_error_ff(panel_error_ff), .irq_ff(irq_ff));

// ===== sim/tb.sv
`timescale 1ns/10ps
`include "home_seq_defs.vh"
module tb;
  reg         ref_clk, arst_n, reg_wr, reg_rd;
  reg  [7:0]  reg_addr, bad_id;
  reg  [31:0] reg_wdata, rng, q;
  reg  [15:0] clear_up, clear_down;
  reg  [3:0]  lag;
  reg  [2:0]  fail_n;
  reg  [1:0]  sp;
  wire [31:0] reg_rdata_ff;
  wire [7:0]  mid, panel_error_ff;
  wire [1:0]  move_speed_ff;
  wire        move_req_ff, move_done, move_fail, irq_ff;
  integer     n_fail, compares, cyc, k;
  autochanger_home_sequencer dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .move_req_ff(move_req_ff), .micro_move_identifier_ff(mid), .move_speed_ff(move_speed_ff),
    .move_done(move_done), .move_fail(move_fail), .clear_up(clear_up), .clear_down(clear_down),
    .panel_error_ff(panel_error_ff), .irq_ff(irq_ff));
  motion_model mech (.ref_clk(ref_clk), .arst_n(arst_n), .move_req(move_req_ff), .move_id(mid),
    .bad_id(bad_id), .fail_n(fail_n), .lag(lag), .done_ff(move_done), .fail_ff(move_fail));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  function [31:0] nx(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      nx = t ^ (t << 5);
    end
  endfunction
  function [7:0] ecode(input integer s);
    ecode = s == 0 ? `ERR_PICKER : s == 1 ? `ERR_FLIP_AREA : s == 2 ? `ERR_FINGERS : `ERR_HOME_POS;
  endfunction
  function [7:0] eid(input integer s);
    eid = s == 0 ? `MICRO_MOVE_IDENTIFIER_STEP1 : s == 1 ? `MICRO_MOVE_IDENTIFIER_STEP2 : s == 2 ? `MICRO_MOVE_IDENTIFIER_STEP3 : `MICRO_MOVE_IDENTIFIER_STEP4;
  endfunction
  task give_verdict;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // Data stands one cycle only, so sample just after that edge
  task rd(input [7:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      q = reg_rdata_ff;
      @(posedge ref_clk);
    end
  endtask
  task logrd(input [2:0] f);
    begin
      wr(`REG_LOG_SEL, {29'h0, f});
      rd(`REG_LOG_DATA, 32'h0);
    end
  endtask
  task go(input [31:0] ctrl, input [7:0] mask, input [7:0] bid, input [2:0] n);
    begin
      rng = nx(rng);
      lag <= rng[3:0];
      bad_id <= bid;
      fail_n <= n;
      arst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      wr(`REG_IRQ_MASK, {24'h0, mask});
      wr(`REG_CTRL, 32'h10);
      wr(`REG_CTRL, ctrl | 32'h1);
      while (irq_ff !== 1'b1)
        @(posedge ref_clk);
      // Window to catch any stray extra request
      repeat (8) @(posedge ref_clk);
    end
  endtask
  initial begin
    n_fail = 0;
    compares = 0;
    cyc = 0;
    rng = 32'hF404C562;
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    clear_up = 16'h0;
    clear_down = 16'h0;
    lag = 4'h0;
    bad_id = 8'h00;
    fail_n = 3'h0;
    for (k = 0; k < 4; k = k + 1) begin
      sp = rng[5:4] % 3;
      go({28'h0, sp, 2'h0}, 8'h05, eid(k), 3'h1);
      chk("speed", move_speed_ff, sp);
      chk("panel", panel_error_ff, 0);
      rd(`REG_IRQ_STAT, 32'h0);
      chk("irqstat", q, 32'h3);
      @(posedge ref_clk);
      chk("irqclr", irq_ff, 0);
      logrd(`LOG_MM1_ERR);
      chk("mm1err", q, ecode(k));
      logrd(`LOG_MM1_ID);
      chk("mm1id", q, eid(k));
      logrd(`LOG_MOVES);
      chk("moves", q, k + 5);
      $display("test step fault %0d done", k);
    end
    k = rng[7:6];
    go(32'h0, 8'h04, eid(k), 3'h4);
    chk("panel", panel_error_ff, `ERR_HARDWARE);
    rd(`REG_FAIL_UNITS, 32'h0);
    chk("units", q, 32'h7);
    rd(`REG_STATUS, 32'h0);
    chk("failcnt", q[6:4], 4);
    logrd(`LOG_MOVES);
    chk("moves", q, 4 * (k + 1));
    logrd(`LOG_MM2_ERR);
    chk("mm2err", q, ecode(k));
    $display("test hardware error done");
    k = rng[9:8];
    go(32'h2, 8'h07, eid(k), 3'h1);
    logrd(`LOG_MOVES);
    chk("moves", q, k + 1);
    chk("panel", panel_error_ff, 0);
    $display("test single run done");
    rng = nx(rng);
    clear_up <= rng[31:16] | 16'h8000;
    clear_down <= rng[15:0];
    rd(`REG_CLEARANCE, 32'h0);
    chk("clear", q, {rng[31:16] | 16'h8000, rng[15:0]});
    rd(`REG_SLOT_QUERY, {16'h0, rng[15:0]});
    chk("group", q, rng[15:2] + 1);
    logrd(`LOG_TILT);
    chk("tilt", q, 0);
    rd(8'hFC, 32'h0);
    chk("unmapped", q, 0);
    $display("test registers done");
    give_verdict;
  end
endmodule
